/* File: ssm_core.sv */
// ssm_core: synchronous half-duplex serial port, master and slave
// assumes: avalon-mm master on i_sys_clk; clock and data pins are async
// Behaviour
// - load shifter only after last bit out
// - load takes one cycle, then empty flag
// - empty flag: hardware set, cleared by write
// - tx request only with tx enable
// - shift_empty_status readable, polled, no request
// - shift register has no address
// - ninth bit sent from tx_ninth_bit_value
// - buffer write starts transmission when enabled
// - continuous enable, or single enable in master mode, starts reception
// - sample data on trailing clock edge
// - single mode receives one word only
// - continuous mode repeats until cleared
// - both enables set acts as continuous
// - receive done sets flag, gated request
// - ninth bit and errors in control register
// - clearing continuous enable clears errors
// - clock source clear selects slave mode
// - slave shifts on the external clock
// - half duplex: transmit xor receive
// - clock idles at polarity bit level
//
// Our own choices: the Avalon-MM register port and the register addresses.
`timescale 1ns/1ps
module ssm_core (
    input  wire logic                 i_sys_clk,      // 20 MHz system clock
    input  wire logic                 i_reset_n,      // async reset, low
    input  wire ssm_pkg::ssm_avs_req_t i_avs,         // register request
    output      ssm_pkg::ssm_avs_rsp_t o_avs,         // register answer
    input  wire logic                 i_shift_clk,    // clock pin level
    output      logic                 o_shift_clk,    // clock pin drive
    output      logic                 o_shift_clk_oe, // clock pin enable
    input  wire logic                 i_sync_data,    // data pin level
    output      logic                 o_sync_data,    // data pin drive
    output      logic                 o_sync_data_oe, // data pin enable
    output      logic                 o_tx_irq,       // transmit request
    output      logic                 o_rx_irq        // receive request
);
    import ssm_pkg::*;

    // whole state of the port
    typedef struct packed {
        logic        avs_wait;  // waitrequest level
        logic [31:0] rdata;     // captured read word
        logic        clock_source_select;      // clock_source_select
        logic        tx9en;     // tx_ninth_bit_enable
        logic        transmit_enable;      // transmit_enable
        logic        sync;      // synchronous select
        logic        tx_ninth_bit_value;      // tx_ninth_bit_value
        logic        port_enable;      // port_enable
        logic        rx9en;     // rx_ninth_bit_enable
        logic        single_receive_enable;      // single_receive_enable
        logic        continuous_receive_enable;      // continuous_receive_enable
        logic        ovr;       // overrun_error_status
        logic        rx_ninth_bit_value;      // rx_ninth_bit_value
        logic        pol;       // clock_idle_polarity
        logic        wide;      // wide_divider_select
        logic [7:0]  divh;      // baud_divider_high
        logic [7:0]  divl;      // baud_divider_low
        logic [7:0]  txbuf;     // transmit_buffer
        logic        txf;       // tx_buffer_empty_flag
        logic [7:0]  rxbuf;     // receive_buffer
        logic        rxf;       // rx_complete_flag
        logic        txie;      // tx_interrupt_enable
        logic        rxie;      // rx_interrupt_enable
        ssm_mode_t   mode;      // link activity
        logic [8:0]  shreg;     // tx_shift_register / receive shifter
        logic [3:0]  bitcnt;    // bits left in the word
        logic        word9;     // word is nine bits
        logic [15:0] baud_cnt;  // half period counter
        logic        clk_lvl;   // master clock level
        logic        sck_m;     // clock pin, first stage
        logic        sck_s;     // clock pin, second stage
        logic        sck_d;     // second stage, delayed
        logic        dat_m;     // data pin, first stage
        logic        dat_s;     // data pin, second stage
        logic        dat_o;     // data drive
        logic        dat_oe;    // data enable
        logic        clk_oe;    // clock enable
        logic        tx_irq;    // gated transmit request
        logic        rx_irq;    // gated receive request
    } ssm_state_t;

    ssm_state_t st_reg;   // registered state
    ssm_state_t st_next;  // next state

    // helpers, also watched by the checks
    logic        take;     // request accepted this edge
    logic        wr_en;    // accepted write, low lane on
    logic        wr_tx;    // accepted write to transmit_buffer
    logic        rd_rx;    // accepted read of receive_buffer
    logic        tx_load;  // buffer moves to shifter
    logic        lead;     // clock leaves idle level
    logic        trail;    // clock returns to idle level
    logic        rx_done;  // word received
    logic        tx_done;  // word sent
    logic        rx_on;    // reception requested
    logic [15:0] div;      // effective divider
    logic [8:0]  rx_sh;    // shifter with new sample
    logic [3:0]  nbits_t;  // transmit word length
    logic [3:0]  nbits_r;  // receive word length

    // read mux, zero for unmapped offsets
    function automatic logic [31:0] rd_word(input logic [5:0] a,
                                            input ssm_state_t s);
        logic [7:0] v;
        v = 8'h00;
        case (a)
            OFS_TXCTL: begin
                v[B_CLOCK_SOURCE_SELECT]  = s.clock_source_select;
                v[B_TX9]   = s.tx9en;
                v[B_TRANSMIT_ENABLE]  = s.transmit_enable;
                v[B_SYNC]  = s.sync;
                v[B_TEMPT] = (s.mode != SSM_TX);
                v[B_TX_NINTH_BIT_VALUE]  = s.tx_ninth_bit_value;
            end
            OFS_RXCTL: begin
                v[B_PORT_ENABLE] = s.port_enable;
                v[B_RX9]  = s.rx9en;
                v[B_SINGLE_RECEIVE_ENABLE] = s.single_receive_enable;
                v[B_CONTINUOUS_RECEIVE_ENABLE] = s.continuous_receive_enable;
                v[B_OVR]  = s.ovr;
                v[B_RX_NINTH_BIT_VALUE] = s.rx_ninth_bit_value;
            end
            OFS_TXBUF: v = s.txbuf;
            OFS_RXBUF: v = s.rxbuf;
            OFS_BAUD: begin
                v[B_POL]  = s.pol;
                v[B_WIDE] = s.wide;
            end
            OFS_DIVH: v = s.divh;
            OFS_DIVL: v = s.divl;
            OFS_FLAG: begin
                v[B_RXF] = s.rxf;
                v[B_TXF] = s.txf;
            end
            OFS_IEN: begin
                v[B_RXF] = s.rxie;
                v[B_TXF] = s.txie;
            end
            default: v = 8'h00;
        endcase
        // the shifter itself is never readable
        return {24'h000000, v};
    endfunction

    // next state
    always_comb begin
        st_next = st_reg;
        // bus handshake: one stall cycle, then accept
        take  = (i_avs.read | i_avs.write) & ~st_reg.avs_wait;
        wr_en = take & i_avs.write & i_avs.byteenable[0];
        wr_tx = wr_en & (i_avs.address == OFS_TXBUF);
        rd_rx = take & i_avs.read & (i_avs.address == OFS_RXBUF);
        st_next.avs_wait = ~((i_avs.read | i_avs.write) & st_reg.avs_wait);
        if ((i_avs.read | i_avs.write) & st_reg.avs_wait) begin
            st_next.rdata = rd_word(i_avs.address, st_reg);
        end

        // pin synchronisers
        st_next.sck_m = i_shift_clk;
        st_next.sck_s = st_reg.sck_m;
        st_next.sck_d = st_reg.sck_s;
        st_next.dat_m = i_sync_data;
        st_next.dat_s = st_reg.dat_m;

        // register writes
        if (wr_en) begin
            case (i_avs.address)
                OFS_TXCTL: begin
                    st_next.clock_source_select  = i_avs.writedata[B_CLOCK_SOURCE_SELECT];
                    st_next.tx9en = i_avs.writedata[B_TX9];
                    st_next.transmit_enable  = i_avs.writedata[B_TRANSMIT_ENABLE];
                    st_next.sync  = i_avs.writedata[B_SYNC];
                    st_next.tx_ninth_bit_value  = i_avs.writedata[B_TX_NINTH_BIT_VALUE];
                end
                OFS_RXCTL: begin
                    st_next.port_enable  = i_avs.writedata[B_PORT_ENABLE];
                    st_next.rx9en = i_avs.writedata[B_RX9];
                    st_next.single_receive_enable  = i_avs.writedata[B_SINGLE_RECEIVE_ENABLE];
                    st_next.continuous_receive_enable  = i_avs.writedata[B_CONTINUOUS_RECEIVE_ENABLE];
                    // dropping continuous mode wipes errors
                    if (!i_avs.writedata[B_CONTINUOUS_RECEIVE_ENABLE]) begin
                        st_next.ovr = 1'b0;
                    end
                end
                OFS_TXBUF: begin
                    st_next.txbuf = i_avs.writedata[7:0];
                    st_next.txf   = 1'b0;
                end
                OFS_BAUD: begin
                    st_next.pol  = i_avs.writedata[B_POL];
                    st_next.wide = i_avs.writedata[B_WIDE];
                end
                OFS_DIVH: st_next.divh = i_avs.writedata[7:0];
                OFS_DIVL: st_next.divl = i_avs.writedata[7:0];
                OFS_IEN: begin
                    st_next.rxie = i_avs.writedata[B_RXF];
                    st_next.txie = i_avs.writedata[B_TXF];
                end
                // flag register and unmapped offsets ignore writes
                default: st_next.rxbuf = st_reg.rxbuf;
            endcase
        end
        // reading the received word empties it
        if (rd_rx) begin
            st_next.rxf = 1'b0;
        end

        // effective divider
        div     = st_reg.wide ? {st_reg.divh, st_reg.divl}
                              : {8'h00, st_reg.divl};
        nbits_t = st_reg.tx9en ? BITS9 : BITS8;
        nbits_r = st_reg.rx9en ? BITS9 : BITS8;
        // single mode counts only as master; a slave receives in continuous mode only
        rx_on   = st_reg.continuous_receive_enable | (st_reg.single_receive_enable & st_reg.clock_source_select);

        // shift clock edges
        lead  = 1'b0;
        trail = 1'b0;
        if (st_reg.clock_source_select) begin
            // master: clock only while a word moves
            if (st_reg.mode != SSM_IDLE) begin
                if (st_reg.baud_cnt >= div) begin
                    st_next.baud_cnt = 16'h0000;
                    st_next.clk_lvl  = ~st_reg.clk_lvl;
                    lead  = (st_reg.clk_lvl == st_reg.pol);
                    trail = (st_reg.clk_lvl != st_reg.pol);
                end else begin
                    st_next.baud_cnt = st_reg.baud_cnt + 16'h0001;
                end
            end else begin
                // parked at the idle level
                st_next.baud_cnt = 16'h0000;
                st_next.clk_lvl  = st_next.pol;
            end
        end else begin
            // slave: edges of the external clock
            st_next.baud_cnt = 16'h0000;
            st_next.clk_lvl  = st_next.pol;
            if (st_reg.sck_s != st_reg.sck_d) begin
                lead  = (st_reg.sck_d == st_reg.pol);
                trail = (st_reg.sck_s == st_reg.pol);
            end
        end

        // new receive sample enters at the top
        rx_sh   = {st_reg.dat_s, st_reg.shreg[8:1]};
        tx_load = 1'b0;
        tx_done = 1'b0;
        rx_done = 1'b0;

        // link sequencing
        case (st_reg.mode)
            SSM_IDLE: begin
                if (st_reg.port_enable & st_reg.sync) begin
                    // transmit wins; a write cycle delays the load
                    if (st_reg.transmit_enable & ~st_reg.txf & ~wr_tx) begin
                        tx_load = 1'b1;
                    end else if (rx_on) begin
                        st_next.mode   = SSM_RX;
                        st_next.bitcnt = nbits_r;
                        st_next.word9  = st_reg.rx9en;
                        st_next.shreg  = 9'h000;
                    end
                end
            end
            SSM_TX: begin
                if (~st_reg.port_enable | ~st_reg.transmit_enable) begin
                    // transmitter switched off mid-word
                    st_next.mode = SSM_IDLE;
                end else begin
                    // new bit leaves on the leading edge
                    if (lead) begin
                        st_next.dat_o = st_reg.shreg[0];
                        st_next.shreg = {1'b0, st_reg.shreg[8:1]};
                    end
                    // peer samples on the trailing edge
                    if (trail) begin
                        st_next.bitcnt = st_reg.bitcnt - 4'h1;
                        if (st_reg.bitcnt == 4'h1) begin
                            tx_done = 1'b1;
                            // next word follows at once if waiting
                            if (~st_reg.txf & ~wr_tx) begin
                                tx_load = 1'b1;
                            end else begin
                                st_next.mode = SSM_IDLE;
                            end
                        end
                    end
                end
            end
            SSM_RX: begin
                if (~st_reg.port_enable | ~rx_on) begin
                    // reception withdrawn mid-word
                    st_next.mode = SSM_IDLE;
                end else if (trail) begin
                    st_next.shreg  = rx_sh;
                    st_next.bitcnt = st_reg.bitcnt - 4'h1;
                    if (st_reg.bitcnt == 4'h1) begin
                        rx_done = 1'b1;
                        if (st_reg.continuous_receive_enable) begin
                            // continuous: start the next word
                            st_next.bitcnt = nbits_r;
                            st_next.word9  = st_reg.rx9en;
                        end else begin
                            // single: one word then stop
                            st_next.single_receive_enable = 1'b0;
                            st_next.mode = SSM_IDLE;
                        end
                    end
                end
            end
            default: st_next.mode = SSM_IDLE;
        endcase

        // buffer to shifter in one cycle
        if (tx_load) begin
            st_next.mode   = SSM_TX;
            st_next.shreg  = {st_reg.tx_ninth_bit_value & st_reg.tx9en, st_reg.txbuf};
            st_next.bitcnt = nbits_t;
            st_next.word9  = st_reg.tx9en;
            st_next.txf    = 1'b1;
        end

        // word complete: store or flag overrun
        if (rx_done) begin
            if (st_next.rxf) begin
                st_next.ovr = 1'b1;
            end else begin
                st_next.rxbuf = st_reg.word9 ? rx_sh[7:0] : rx_sh[8:1];
                st_next.rx_ninth_bit_value  = st_reg.word9 & rx_sh[8];
                st_next.rxf   = 1'b1;
            end
        end

        // pin drive
        st_next.clk_oe = st_next.port_enable & st_next.sync & st_next.clock_source_select;
        // hold the line one cycle past the last sampling edge, so the
        // peer never sees data and clock change together
        st_next.dat_oe = (st_next.mode == SSM_TX) | (st_reg.mode == SSM_TX);
        // gated requests
        st_next.tx_irq = st_next.txf & st_next.txie;
        st_next.rx_irq = st_next.rxf & st_next.rxie;
    end

    // state register
    always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            st_reg          <= '0;
            st_reg.txf      <= RST_TXF;
            st_reg.avs_wait <= RST_WAIT;
        end else begin
            st_reg <= st_next;
        end
    end

    // outputs straight from flops
    assign o_avs.waitrequest = st_reg.avs_wait;
    assign o_avs.readdata    = st_reg.rdata;
    assign o_shift_clk       = st_reg.clk_lvl;
    assign o_shift_clk_oe    = st_reg.clk_oe;
    assign o_sync_data       = st_reg.dat_o;
    assign o_sync_data_oe    = st_reg.dat_oe;
    assign o_tx_irq          = st_reg.tx_irq;
    assign o_rx_irq          = st_reg.rx_irq;

    // checks
    default clocking cb @(posedge i_sys_clk); endclocking
    default disable iff (!i_reset_n);

    // a load followed by the flag
    sequence seq_load;
        tx_load ##1 st_reg.txf;
    endsequence

    // a single-mode word end
    sequence seq_single_end;
        rx_done && !st_reg.continuous_receive_enable;
    endsequence

    AST_LOAD_FLAG: assert property (
        tx_load |-> seq_load
    ) else $error("load did not set empty flag");

    AST_LOAD_SETS: assert property (
        tx_load |=> st_reg.mode == SSM_TX && st_reg.shreg[7:0] == $past(st_reg.txbuf)
            && st_reg.shreg[8] == $past(st_reg.tx_ninth_bit_value && st_reg.tx9en)
    ) else $error("load did not take the buffered word");

    AST_FLAG_HOLD: assert property (
        st_reg.txf && !wr_tx |=> st_reg.txf
    ) else $error("empty flag dropped without write");

    AST_FLAG_CLR: assert property (
        wr_tx |=> !st_reg.txf
    ) else $error("buffer write left empty flag set");

    AST_TX_IRQ_GATE: assert property (
        o_tx_irq == (st_reg.txf && st_reg.txie)
    ) else $error("tx request without enable");

    AST_NO_LOAD_MIDWORD: assert property (
        tx_load && st_reg.mode == SSM_TX |-> tx_done
    ) else $error("shifter loaded mid-word");

    AST_HALF_DUPLEX: assert property (
        st_reg.mode == SSM_RX |-> !o_sync_data_oe
    ) else $error("data driven during reception");

    AST_SINGLE_STOP: assert property (
        seq_single_end |=> !st_reg.single_receive_enable && st_reg.mode == SSM_IDLE
    ) else $error("single mode kept receiving");

    AST_RX_FLAG: assert property (
        rx_done && !st_reg.rxf && !rd_rx |=> st_reg.rxf ##1 1'b1
    ) else $error("word end did not set flag");

    AST_CONT_CLR: assert property (
        $fell(st_reg.continuous_receive_enable) && !$past(rx_done) |-> !st_reg.ovr
    ) else $error("error kept after continuous cleared");

    AST_CLK_IDLE: assert property (
        st_reg.clock_source_select && st_reg.mode == SSM_IDLE && $stable(st_reg.pol)
            && $past(st_reg.mode) == SSM_IDLE |-> o_shift_clk == st_reg.pol
    ) else $error("clock not at idle level");
endmodule

/* File: ssm_pkg.sv */
// ssm_pkg: shared constants and carriers of the synchronous serial port
// assumes: avalon-mm byte addresses, one 32-bit word per register
package ssm_pkg;
    // register byte offsets
    localparam logic [5:0] OFS_TXCTL = 6'h00; // transmit_control_status
    localparam logic [5:0] OFS_RXCTL = 6'h04; // receive_control_status
    localparam logic [5:0] OFS_TXBUF = 6'h08; // transmit_buffer
    localparam logic [5:0] OFS_RXBUF = 6'h0C; // receive_buffer
    localparam logic [5:0] OFS_BAUD  = 6'h10; // baud_control
    localparam logic [5:0] OFS_DIVH  = 6'h14; // baud_divider_high
    localparam logic [5:0] OFS_DIVL  = 6'h18; // baud_divider_low
    localparam logic [5:0] OFS_FLAG  = 6'h1C; // peripheral_flag_register
    localparam logic [5:0] OFS_IEN   = 6'h20; // peripheral_enable_register
    // transmit_control_status fields
    localparam int B_CLOCK_SOURCE_SELECT  = 7; // clock_source_select
    localparam int B_TX9   = 6; // tx_ninth_bit_enable
    localparam int B_TRANSMIT_ENABLE  = 5; // transmit_enable
    localparam int B_SYNC  = 4; // synchronous select
    localparam int B_TEMPT = 1; // shift_empty_status, read only
    localparam int B_TX_NINTH_BIT_VALUE  = 0; // tx_ninth_bit_value
    // receive_control_status fields
    localparam int B_PORT_ENABLE  = 7; // port_enable
    localparam int B_RX9   = 6; // rx_ninth_bit_enable
    localparam int B_SINGLE_RECEIVE_ENABLE  = 5; // single_receive_enable
    localparam int B_CONTINUOUS_RECEIVE_ENABLE  = 4; // continuous_receive_enable
    localparam int B_FRM   = 2; // framing_error_status, always zero here
    localparam int B_OVR   = 1; // overrun_error_status
    localparam int B_RX_NINTH_BIT_VALUE  = 0; // rx_ninth_bit_value
    // baud_control fields
    localparam int B_POL   = 4; // clock_idle_polarity
    localparam int B_WIDE  = 3; // wide_divider_select
    // flag and enable fields
    localparam int B_RXF   = 5; // rx_complete_flag / rx_interrupt_enable
    localparam int B_TXF   = 4; // tx_buffer_empty_flag / tx_interrupt_enable
    // reset values
    localparam logic       RST_TXF  = 1'b1; // buffer starts empty
    localparam logic       RST_WAIT = 1'b1; // bus stalls until a request
    localparam logic [3:0] BITS8    = 4'h8; // word length, 8-bit
    localparam logic [3:0] BITS9    = 4'h9; // word length, 9-bit
    // link activity
    typedef enum logic [1:0] {SSM_IDLE, SSM_TX, SSM_RX} ssm_mode_t;
    // avalon-mm request from the master
    typedef struct packed {
        logic        read;
        logic        write;
        logic [5:0]  address;
        logic [3:0]  byteenable;
        logic [31:0] writedata;
    } ssm_avs_req_t;
    // avalon-mm answer to the master
    typedef struct packed {
        logic        waitrequest;
        logic [31:0] readdata;
    } ssm_avs_rsp_t;
endpackage

/* File: ssm_peer.sv */
// ssm_peer: behavioural far-side peer on the shift clock and data lines
// assumes: device is master, clock idles low, peer never drives the clock
`timescale 1ns/1ps
module ssm_peer (
    input  wire logic       i_ck,    // clock line level
    input  wire logic       i_dt,    // data line level
    input  wire logic       i_dt_oe, // device drives data
    input  wire logic [7:0] i_word,  // word sent to the device
    output      logic       o_dt,    // data drive
    output      logic [8:0] o_got    // last nine bits seen
);
    int idx = 0; // next bit to send
    initial o_dt = 1'b0;
    initial o_got = 9'h000;
    // send lsb first, change on the leading edge
    always @(posedge i_ck) begin
        if (!i_dt_oe) begin
            o_dt <= i_word[idx];
            idx  <= (idx + 1) % 8;
        end
    end
    // capture on the trailing edge, lsb arrives first
    always @(negedge i_ck) begin
        if (i_dt_oe) begin
            o_got <= {i_dt, o_got[8:1]};
        end
    end
endmodule

/* File: tb.sv */
// tb: register-level tests of the serial port with a peer on the link
// assumes: divider 3 gives a 400 ns shift clock at 20 MHz
`timescale 1ns/1ps
module tb;
    import ssm_pkg::*;
    logic         i_sys_clk = 1'b0; // system clock
    logic         i_reset_n = 1'b0; // reset, low
    ssm_avs_req_t req = '0;         // bus request
    ssm_avs_rsp_t rsp;              // bus answer
    logic         ck, ck_oe, dt, dt_oe, p_dt, tx_irq, rx_irq;
    logic [8:0]   got;              // peer capture
    wire          ck_w = ck_oe ? ck : 1'b0;    // clock stands still otherwise
    wire          dt_w = dt_oe ? dt : p_dt;    // data line level
    int           fail_count = 0;
    int           n_checks = 0;
    int           edges = 0;        // shift clock rising edges
    int           e0;
    logic [31:0]  q;
    ssm_core i_dut (.i_sys_clk(i_sys_clk), .i_reset_n(i_reset_n), .i_avs(req), .o_avs(rsp),
        .i_shift_clk(ck_w), .o_shift_clk(ck), .o_shift_clk_oe(ck_oe), .i_sync_data(dt_w),
        .o_sync_data(dt), .o_sync_data_oe(dt_oe), .o_tx_irq(tx_irq), .o_rx_irq(rx_irq));
    ssm_peer i_peer (.i_ck(ck_w), .i_dt(dt_w), .i_dt_oe(dt_oe), .i_word(8'h96),
        .o_dt(p_dt), .o_got(got));
    // clock generator
    initial begin
        forever #25 i_sys_clk = ~i_sys_clk;
    end
    // count shift clock pulses
    always @(posedge ck_w) edges++;
    task chk(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("CHECK FAILED t=%0t seen %h exp %h", $time, seen, exp);
        end
    endtask
    // one avalon cycle, held until waitrequest is sampled low
    task bus(input logic wr, input logic [5:0] a, input logic [7:0] d);
        @(posedge i_sys_clk);
        req.write <= wr;
        req.read <= !wr;
        req.address <= a;
        req.byteenable <= 4'hF;
        req.writedata <= {24'h000000, d};
        // only the watchdog ends a wait that never finishes
        do begin
            @(posedge i_sys_clk);
        end while (rsp.waitrequest !== 1'b0);
        q = rsp.readdata;
        req.read <= 1'b0;
        req.write <= 1'b0;
    endtask
    task wr(input logic [5:0] a, input logic [7:0] d);
        bus(1'b1, a, d);
    endtask
    task rd(input logic [5:0] a, input logic [31:0] m, input logic [31:0] e);
        bus(1'b0, a, 8'h00);
        chk(q & m, e);
    endtask
    // read until a bit of m is set, load takes up to 2 cycles
    task poll(input logic [5:0] a, input logic [31:0] m);
        repeat (3) @(posedge i_sys_clk);
        for (int i = 0; i < 300; i++) begin
            bus(1'b0, a, 8'h00);
            if ((q & m) != 0) break;
        end
        chk(q & m, m);
    endtask
    task give_verdict;
        $display("checks %0d failures %0d", n_checks, fail_count);
        if (fail_count == 0 && n_checks > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    // watchdog
    initial begin
        #2000000;
        fail_count++;
        give_verdict();
    end
    // main sequence
    initial begin
        repeat (10) @(posedge i_sys_clk);
        i_reset_n <= 1'b1;
        rd(OFS_FLAG, 32'hFF, 32'h10);
        rd(OFS_TXCTL, 32'hFF, 32'h02);
        rd(6'h24, 32'hFFFFFFFF, 32'h0);
        wr(OFS_FLAG, 8'h00);
        rd(OFS_FLAG, 32'hFF, 32'h10);
        chk(tx_irq, 1'b0);
        wr(OFS_IEN, 8'h10);
        repeat (2) @(posedge i_sys_clk);
        chk(tx_irq, 1'b1);
        wr(OFS_IEN, 8'h00);
        $display("test reset done");
        wr(OFS_DIVL, 8'h03);
        wr(OFS_DIVH, 8'h00);
        wr(OFS_BAUD, 8'h00);
        wr(OFS_RXCTL, 8'h80);
        wr(OFS_TXCTL, 8'hB0);
        @(posedge i_sys_clk);
        chk({ck_oe, ck}, 2'b10);
        wr(OFS_TXBUF, 8'hA5);
        wr(OFS_TXBUF, 8'h3C);
        rd(OFS_FLAG, 32'h10, 32'h00);
        rd(OFS_TXCTL, 32'h02, 32'h00);
        poll(OFS_FLAG, 32'h10);
        chk(got[8:1], 8'hA5);
        poll(OFS_TXCTL, 32'h02);
        chk(got[8:1], 8'h3C);
        chk(edges, 16);
        wr(OFS_TXCTL, 8'hF1);
        wr(OFS_TXBUF, 8'h00);
        poll(OFS_TXCTL, 32'h02);
        chk(got, 9'h100);
        $display("test transmit done");
        wr(OFS_IEN, 8'h20);
        wr(OFS_TXCTL, 8'h90);
        e0 = edges;
        wr(OFS_RXCTL, 8'hA0);
        poll(OFS_FLAG, 32'h20);
        chk(rx_irq, 1'b1);
        rd(OFS_RXCTL, 32'hFF, 32'h80);
        rd(OFS_RXBUF, 32'hFF, 32'h96);
        repeat (100) @(posedge i_sys_clk);
        chk(rx_irq, 1'b0);
        chk(edges, e0 + 8);
        wr(OFS_RXCTL, 8'h80);
        wr(OFS_RXCTL, 8'hB0);
        poll(OFS_RXCTL, 32'h02);
        wr(OFS_RXCTL, 8'h80);
        rd(OFS_RXCTL, 32'h02, 32'h00);
        rd(OFS_RXBUF, 32'hFF, 32'h96);
        $display("test receive done");
        wr(OFS_TXCTL, 8'h10);
        repeat (2) @(posedge i_sys_clk);
        chk(ck_oe, 1'b0);
        wr(OFS_TXCTL, 8'h90);
        wr(OFS_BAUD, 8'h10);
        repeat (2) @(posedge i_sys_clk);
        chk(ck, 1'b1);
        $display("test mode done");
        give_verdict();
    end
endmodule
